// ---- core/hti_sensor_dev.sv ----
// sensor end: two-wire slave, measurement sequencer and result register
//
`timescale 1ns/10ps

// How it works
// RULE1: acknowledge only address 0x44, ignore others
// RULE2: oversampled link works at 100k and 400k
// RULE3: master frames transfers with start and stop
// RULE4: sample on scl rise, change only while low
// RULE5: address then direction bit, one means read
// RULE6: eight bits then receiver acknowledge bit
// RULE7: after ack, next byte or stop follows
// RULE8: sleep until request, core powered down
// RULE9: acked write address starts a measurement
// RULE10: humidity, temperature, then update result, sleep
// RULE11: results are 14 bits, msb first
// RULE12: acked read address then result bytes
// RULE13: send bytes until master nacks and stops
// RULE14: byte one: status top, then humidity
// RULE15: bytes three, four: temperature, low bits undefined
// RULE16: master may stop after byte two or three
// RULE17: cycle time follows resolution plus wake
// RULE18: master waits or checks status before fetch
// RULE19: status 00 when unread since last cycle
// RULE20: status 01 once read since last cycle
// RULE21: fetch before first completed cycle reads stale
// RULE22: each conversion time follows its resolution
// RULE23: status codes 10 and 11 never produced
module hti_sensor_dev
  import hti_pkg::*;
#(
  parameter int WAKE_CYC   = HTI_WAKE_CYC,
  parameter int CONV8_CYC  = HTI_CONV8_CYC,
  parameter int CONV10_CYC = HTI_CONV10_CYC,
  parameter int CONV12_CYC = HTI_CONV12_CYC,
  parameter int CONV14_CYC = HTI_CONV14_CYC
)
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // link
  hti_i2c_if.dev           bus,
  // sensing core
  input  wire logic [1:0]  i_res_sel,
  input  wire logic [13:0] i_hum_value,
  input  wire logic [13:0] i_temp_value,
  // status
  output logic             o_core_on,
  output logic             o_meas_done,
  output logic             o_result_fresh
);

  // ----------------------------------------------------------------
  // types and signals
  // ----------------------------------------------------------------
  typedef enum logic [6:0]
  {
    LK_IDLE = 7'b0000001,
    LK_ADDR = 7'b0000010,
    LK_AACK = 7'b0000100,
    LK_WRX  = 7'b0001000,
    LK_WACK = 7'b0010000,
    LK_TX   = 7'b0100000,
    LK_TACK = 7'b1000000
  } hti_link_e;

  typedef enum logic [3:0]
  {
    MS_SLEEP = 4'b0001,
    MS_WAKE  = 4'b0010,
    MS_HUM   = 4'b0100,
    MS_TEMP  = 4'b1000
  } hti_meas_e;

  logic [1:0]           pin_s1_reg;
  logic [1:0]           pin_s2_reg;
  logic [1:0]           pin_s3_reg;
  logic [1:0]           pin_flt_reg;
  logic [1:0]           pin_prv_reg;
  hti_link_e            link_reg;
  logic [2:0]           bit_cnt_reg;
  logic                 byte_done_reg;
  logic [7:0]           rx_sh_reg;
  logic                 dir_reg;
  logic                 mnack_reg;
  logic [31:0]          tx_word_reg;
  logic                 sda_oe_reg;
  hti_meas_e            meas_reg;
  logic [HTI_TMR_W-1:0] tmr_reg;
  logic [1:0]           res_reg;
  logic [13:0]          hum_work_reg;
  logic [13:0]          res_hum_reg;
  logic [13:0]          res_temp_reg;
  logic                 fresh_reg;
  logic                 core_on_reg;
  logic                 done_reg;
  logic                 scl_f;
  logic                 sda_f;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  logic                 addr_hit;
  logic                 meas_req;
  logic                 fetch_go;
  logic [31:0]          snap_word;
  logic [13:0]          res_mask;

  // ----------------------------------------------------------------
  // pin synchronisers and filter
  // ----------------------------------------------------------------
  // three stages; a level is taken only when stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_s1_reg <= 2'h3;
      pin_s2_reg <= 2'h3;
      pin_s3_reg <= 2'h3;
    end
    else
    begin
      pin_s1_reg <= {bus.scl, bus.sda};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  generate
    for (genvar gi = 0; gi < 2; gi++)
    begin : g_flt
      always_ff @(posedge i_sys_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          pin_flt_reg[gi] <= 1'b1;
          pin_prv_reg[gi] <= 1'b1;
        end
        else
        begin
          if (pin_s2_reg[gi] == pin_s3_reg[gi])
            pin_flt_reg[gi] <= pin_s3_reg[gi];
          pin_prv_reg[gi] <= pin_flt_reg[gi];
        end
      end
    end
  endgenerate

  // edge and condition detection, at 100 MHz far finer than either bit rate
  assign scl_f     = pin_flt_reg[1];
  assign sda_f     = pin_flt_reg[0];
  assign scl_rise  = scl_f & ~pin_prv_reg[1];                        // [RULE2] [RULE4]
  assign scl_fall  = ~scl_f & pin_prv_reg[1];
  assign start_det = scl_f & pin_prv_reg[1] & pin_prv_reg[0] & ~sda_f; // [RULE3]
  assign stop_det  = scl_f & pin_prv_reg[1] & ~pin_prv_reg[0] & sda_f; // [RULE3]
  assign addr_hit  = (rx_sh_reg[7:1] == HTI_SLAVE_ADDR);            // [RULE1] [RULE5]
  assign meas_req  = (link_reg == LK_AACK) & scl_fall & (dir_reg == HTI_DIR_WRITE); // [RULE9]
  assign fetch_go  = (link_reg == LK_AACK) & scl_fall & (dir_reg == HTI_DIR_READ);  // [RULE12]

  // status field only ever takes the valid or stale code
  assign snap_word = {(fresh_reg ? HTI_STAT_VALID : HTI_STAT_STALE), // [RULE19] [RULE20] [RULE23]
                      res_hum_reg, res_temp_reg, 2'h0};             // [RULE14] [RULE15]

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  // stop and start override any state, so a foreign transfer resyncs us
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      link_reg <= LK_IDLE;
    else if (stop_det)
      link_reg <= LK_IDLE;                                          // [RULE7]
    else if (start_det)
      link_reg <= LK_ADDR;
    else if (scl_fall)
    begin
      case (link_reg)
        LK_ADDR: if (byte_done_reg) link_reg <= addr_hit ? LK_AACK : LK_IDLE; // [RULE1]
        LK_AACK: link_reg <= dir_reg ? LK_TX : LK_WRX;
        LK_WRX:  if (byte_done_reg) link_reg <= LK_WACK;
        LK_WACK: link_reg <= LK_WRX;
        LK_TX:   if (byte_done_reg) link_reg <= LK_TACK;
        LK_TACK: link_reg <= mnack_reg ? LK_IDLE : LK_TX;           // [RULE13]
        default: link_reg <= LK_IDLE;
      endcase
    end
  end

  // bit counting and receive shifting on scl rise
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
      rx_sh_reg     <= 8'h00;
      dir_reg       <= 1'b0;
      mnack_reg     <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      bit_cnt_reg   <= 3'h0;
      byte_done_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (link_reg == LK_ADDR || link_reg == LK_WRX)
        rx_sh_reg <= {rx_sh_reg[6:0], sda_f};                       // [RULE4]
      if (link_reg == LK_ADDR || link_reg == LK_WRX || link_reg == LK_TX)
      begin
        bit_cnt_reg   <= bit_cnt_reg + 3'h1;
        byte_done_reg <= (bit_cnt_reg == 3'h7);                     // [RULE6]
      end
      if (link_reg == LK_TACK)
        mnack_reg <= sda_f;                                         // [RULE6] [RULE13]
    end
    else if (scl_fall)
    begin
      if (byte_done_reg)
        byte_done_reg <= 1'b0;
      if (link_reg == LK_ADDR && byte_done_reg)
        dir_reg <= rx_sh_reg[0];                                    // [RULE5]
    end
  end

  // sda drive changes only just after scl falls
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sda_oe_reg  <= 1'b0;
      tx_word_reg <= 32'hFFFFFFFF;
    end
    else if (start_det || stop_det)
      sda_oe_reg <= 1'b0;
    else if (scl_fall)                                              // [RULE4]
    begin
      case (link_reg)
        LK_ADDR: sda_oe_reg <= byte_done_reg & addr_hit;            // [RULE1] [RULE6]
        LK_AACK:
        begin
          tx_word_reg <= snap_word;                                 // [RULE12]
          sda_oe_reg  <= dir_reg & ~snap_word[31];                  // [RULE11]
        end
        LK_WRX:  sda_oe_reg <= byte_done_reg;
        LK_WACK: sda_oe_reg <= 1'b0;
        LK_TX:
        begin
          // past byte four ones are shifted in, so extra bytes read as all ones
          tx_word_reg <= {tx_word_reg[30:0], HTI_FILL_BYTE[0]};      // [RULE13]
          sda_oe_reg  <= byte_done_reg ? 1'b0 : ~tx_word_reg[30];   // [RULE11]
        end
        LK_TACK: sda_oe_reg <= ~mnack_reg & ~tx_word_reg[31];       // [RULE13] [RULE16]
        default: sda_oe_reg <= 1'b0;
      endcase
    end
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = sda_oe_reg;

  // ----------------------------------------------------------------
  // measurement sequencer
  // ----------------------------------------------------------------
  function automatic logic [HTI_TMR_W-1:0] conv_last(input logic [1:0] r);
    case (r)
      HTI_RES_8:  conv_last = HTI_TMR_W'(CONV8_CYC - 1);            // [RULE22]
      HTI_RES_10: conv_last = HTI_TMR_W'(CONV10_CYC - 1);
      HTI_RES_12: conv_last = HTI_TMR_W'(CONV12_CYC - 1);
      default:    conv_last = HTI_TMR_W'(CONV14_CYC - 1);
    endcase
  endfunction

  // lower resolutions still come out left-aligned in 14 bits
  always_comb
  begin
    case (res_reg)
      HTI_RES_8:  res_mask = HTI_MASK_8;                            // [RULE11]
      HTI_RES_10: res_mask = HTI_MASK_10;
      HTI_RES_12: res_mask = HTI_MASK_12;
      default:    res_mask = HTI_MASK_14;
    endcase
  end

  // a request while a cycle runs is ignored; the running cycle completes
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meas_reg     <= MS_SLEEP;                                     // [RULE8]
      tmr_reg      <= '0;
      res_reg      <= HTI_RES_14;
      hum_work_reg <= 14'h0000;
      res_hum_reg  <= 14'h0000;
      res_temp_reg <= 14'h0000;
      core_on_reg  <= 1'b0;
      done_reg     <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (tmr_reg != '0)
        tmr_reg <= tmr_reg - 1'b1;
      case (meas_reg)
        MS_SLEEP:
          if (meas_req)
          begin
            meas_reg    <= MS_WAKE;                                 // [RULE9]
            tmr_reg     <= HTI_TMR_W'(WAKE_CYC - 1);                // [RULE17]
            res_reg     <= i_res_sel;
            core_on_reg <= 1'b1;
          end
        MS_WAKE:
          if (tmr_reg == '0)
          begin
            meas_reg <= MS_HUM;                                     // [RULE10]
            tmr_reg  <= conv_last(res_reg);                         // [RULE17]
          end
        MS_HUM:
          if (tmr_reg == '0)
          begin
            meas_reg     <= MS_TEMP;                                // [RULE10]
            tmr_reg      <= conv_last(res_reg);                     // [RULE22]
            hum_work_reg <= i_hum_value & res_mask;
          end
        MS_TEMP:
          if (tmr_reg == '0)
          begin
            meas_reg     <= MS_SLEEP;                               // [RULE10]
            res_hum_reg  <= hum_work_reg;
            res_temp_reg <= i_temp_value & res_mask;
            core_on_reg  <= 1'b0;                                   // [RULE8]
            done_reg     <= 1'b1;
          end
        default: meas_reg <= MS_SLEEP;
      endcase
    end
  end

  // freshness: completion wins over a fetch in the same cycle (newer data)
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fresh_reg <= 1'b0;                                            // [RULE21]
    else if (meas_reg == MS_TEMP && tmr_reg == '0)
      fresh_reg <= 1'b1;                                            // [RULE19]
    else if (fetch_go)
      fresh_reg <= 1'b0;                                            // [RULE20]
  end

  assign o_core_on      = core_on_reg;
  assign o_meas_done    = done_reg;
  assign o_result_fresh = fresh_reg;

endmodule

// ---- include/hti_pkg.sv ----
// shared constants for the humidity/temperature readout link
package hti_pkg;

  // ----------------------------------------------------------------
  // addressing and status
  // ----------------------------------------------------------------
  localparam logic [6:0] HTI_SLAVE_ADDR = 7'h44;
  localparam logic       HTI_DIR_WRITE  = 1'b0;
  localparam logic       HTI_DIR_READ   = 1'b1;
  localparam logic [1:0] HTI_STAT_VALID = 2'h0;
  localparam logic [1:0] HTI_STAT_STALE = 2'h1;
  localparam logic [7:0] HTI_FILL_BYTE  = 8'hFF;
  localparam int         HTI_MAX_BYTES  = 4;

  // ----------------------------------------------------------------
  // result word layout, 32 bits, byte one in the top lane
  // ----------------------------------------------------------------
  localparam int HTI_VAL_W    = 14;
  localparam int HTI_STAT_POS = 30;
  localparam int HTI_HUM_POS  = 16;
  localparam int HTI_TEMP_POS = 2;

  // ----------------------------------------------------------------
  // resolution codes and masks that keep results scaled to 14 bits
  // ----------------------------------------------------------------
  localparam logic [1:0]  HTI_RES_8     = 2'h0;
  localparam logic [1:0]  HTI_RES_10    = 2'h1;
  localparam logic [1:0]  HTI_RES_12    = 2'h2;
  localparam logic [1:0]  HTI_RES_14    = 2'h3;
  localparam logic [13:0] HTI_MASK_8    = 14'h3FC0;
  localparam logic [13:0] HTI_MASK_10   = 14'h3FF0;
  localparam logic [13:0] HTI_MASK_12   = 14'h3FFC;
  localparam logic [13:0] HTI_MASK_14   = 14'h3FFF;

  // ----------------------------------------------------------------
  // timing; cycle totals are wake plus two conversions
  // ----------------------------------------------------------------
  localparam int HTI_CLK_PERIOD_NS = 10;
  localparam int HTI_WAKE_NS       = 100000;
  localparam int HTI_CONV8_NS      = 550000;
  localparam int HTI_CONV10_NS     = 1310000;
  localparam int HTI_CONV12_NS     = 4500000;
  localparam int HTI_CONV14_NS     = 16900000;
  localparam int HTI_WAKE_CYC      = HTI_WAKE_NS / HTI_CLK_PERIOD_NS;
  localparam int HTI_CONV8_CYC     = HTI_CONV8_NS / HTI_CLK_PERIOD_NS;
  localparam int HTI_CONV10_CYC    = HTI_CONV10_NS / HTI_CLK_PERIOD_NS;
  localparam int HTI_CONV12_CYC    = HTI_CONV12_NS / HTI_CLK_PERIOD_NS;
  localparam int HTI_CONV14_CYC    = HTI_CONV14_NS / HTI_CLK_PERIOD_NS;
  localparam int HTI_TMR_W         = 21;

  // quarter bit times for standard and fast rates, rounded up
  localparam int HTI_QTR_STD_NS  = 2500;
  localparam int HTI_QTR_FAST_NS = 625;
  localparam int HTI_QTR_STD_CYC =
    (HTI_QTR_STD_NS + HTI_CLK_PERIOD_NS - 1) / HTI_CLK_PERIOD_NS;
  localparam int HTI_QTR_FAST_CYC =
    (HTI_QTR_FAST_NS + HTI_CLK_PERIOD_NS - 1) / HTI_CLK_PERIOD_NS;
  localparam int HTI_QTR_W = 8;

endpackage

// ---- include/hti_i2c_if.sv ----
// open-drain two-wire link between bus master and sensor
`timescale 1ns/10ps
interface hti_i2c_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // wired-and with pull-ups: a line is low only where someone drives low
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport host (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport dev  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// ---- core/hti_i2c_host.sv ----
// master end: issues measurement requests and result fetches
`timescale 1ns/10ps
module hti_i2c_host
  import hti_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // link
  hti_i2c_if.host          bus,
  // commands
  input  wire logic        i_fast,
  input  wire logic        i_meas_req,
  input  wire logic        i_fetch_req,
  input  wire logic [2:0]  i_fetch_len,
  // results
  output logic             o_busy,
  output logic             o_done,
  output logic             o_addr_nack,
  output logic [31:0]      o_rx_word
);

  // ----------------------------------------------------------------
  // types and signals
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BIT   = 4'b0100,
    HS_STOP  = 4'b1000
  } hti_host_e;

  hti_host_e            st_reg;
  logic [HTI_QTR_W-1:0] qcnt_reg;
  logic [1:0]           ph_reg;
  logic [3:0]           bit_reg;
  logic [2:0]           byte_reg;
  logic [2:0]           nbytes_reg;
  logic [7:0]           tx_reg;
  logic                 scl_oe_reg;
  logic                 sda_oe_reg;
  logic                 s1_reg;
  logic                 s2_reg;
  logic                 s3_reg;
  logic                 sda_f_reg;
  logic                 busy_reg;
  logic                 done_reg;
  logic                 nack_reg;
  logic [31:0]          rx_reg;
  logic                 tick;
  logic                 slot_low;

  // ----------------------------------------------------------------
  // sda input synchroniser and quarter-bit timer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      sda_f_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= bus.sda;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        sda_f_reg <= s3_reg;
    end
  end

  // scl is made here by division, so it needs no synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      qcnt_reg <= '0;
    else if (st_reg == HS_IDLE || qcnt_reg == '0)
      qcnt_reg <= i_fast ? HTI_QTR_W'(HTI_QTR_FAST_CYC - 1) : HTI_QTR_W'(HTI_QTR_STD_CYC - 1);
    else
      qcnt_reg <= qcnt_reg - 1'b1;
  end

  assign tick = (st_reg != HS_IDLE) && (qcnt_reg == '0);

  // address bits, then ack on data bytes except the last, which gets nack
  assign slot_low = (byte_reg == 3'h0) ? (bit_reg != 4'h8) & ~tx_reg[3'(4'h7 - bit_reg)] :
                    (bit_reg == 4'h8) & (byte_reg != nbytes_reg);

  // ----------------------------------------------------------------
  // transfer sequencer: four quarters per bit
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg     <= HS_IDLE;
      ph_reg     <= 2'h0;
      bit_reg    <= 4'h0;
      byte_reg   <= 3'h0;
      nbytes_reg <= 3'h0;
      tx_reg     <= 8'h00;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      nack_reg   <= 1'b0;
      rx_reg     <= 32'h00000000;
    end
    else
    begin
      done_reg <= 1'b0;
      case (st_reg)
        HS_IDLE:
          if (i_meas_req || i_fetch_req)
          begin
            st_reg   <= HS_START;
            ph_reg   <= 2'h0;
            busy_reg <= 1'b1;
            nack_reg <= 1'b0;
            tx_reg   <= {HTI_SLAVE_ADDR, i_fetch_req ? HTI_DIR_READ : HTI_DIR_WRITE};
            // zero length reads one byte, more than four is cut to four
            nbytes_reg <= !i_fetch_req ? 3'h0 : (i_fetch_len == 3'h0) ? 3'h1 :
                          (i_fetch_len > 3'(HTI_MAX_BYTES)) ? 3'(HTI_MAX_BYTES) : i_fetch_len;
          end
        HS_START:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0)
              sda_oe_reg <= 1'b1;
            else
            begin
              scl_oe_reg <= 1'b1;
              st_reg     <= HS_BIT;
              ph_reg     <= 2'h0;
              bit_reg    <= 4'h0;
              byte_reg   <= 3'h0;
            end
          end
        HS_BIT:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: sda_oe_reg <= slot_low;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2:
                if (bit_reg == 4'h8)
                  nack_reg <= (byte_reg == 3'h0) & sda_f_reg;
                else if (byte_reg != 3'h0)
                  rx_reg <= {rx_reg[30:0], sda_f_reg};
              default:
              begin
                scl_oe_reg <= 1'b1;
                if (bit_reg != 4'h8)
                  bit_reg <= bit_reg + 4'h1;
                else if (nack_reg || byte_reg == nbytes_reg)
                begin
                  st_reg <= HS_STOP;
                  ph_reg <= 2'h0;
                end
                else
                begin
                  bit_reg  <= 4'h0;
                  byte_reg <= byte_reg + 3'h1;
                end
              end
            endcase
          end
        HS_STOP:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default:
              begin
                st_reg   <= HS_IDLE;
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
              end
            endcase
          end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end

  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = scl_oe_reg;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_oe_reg;
  assign o_busy       = busy_reg;
  assign o_done       = done_reg;
  assign o_addr_nack  = nack_reg;
  assign o_rx_word    = rx_reg;

endmodule

// ---- verification/hti_link_sva.sv ----
// checker on the two-wire link between host and sensor ends
`timescale 1ns/10ps
module hti_link_sva (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link wires
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // device data may only move in the low half, else a false start or stop is seen
  AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("device sda moved while scl high");
  AST_DEV_SETUP: assert property ($rose(scl) |-> $past(sda_s_oe, 8) == sda_s_oe)
    else $error("device sda not settled before scl rise");
  AST_DEV_CHG_LOW: assert property ($changed(sda_s_oe) |-> !scl && !$past(scl, 2))
    else $error("device sda changed too soon after scl fall");
  AST_NO_FALSE_START: assert property ($fell(sda) && scl |-> sda_m_oe)
    else $error("sda fell under high scl without host");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  AST_RST_IDLE: assert property ($rose(i_rst_n) |-> !sda_s_oe && !sda_m_oe && !scl_m_oe)
    else $error("link not idle after reset");
  AST_OPEN_DRAIN: assert property (sda_s_oe |-> !sda && !sda_s_o)
    else $error("device drive does not pull sda low");
  // main scenarios reached
  cover property ($rose(sda_s_oe));
  cover property ($fell(sda) && scl);
  cover property ($rose(scl) && sda_s_oe);
endmodule

// ---- verification/humidity_temp_i2c_readout_tb.sv ----
// self-checking bench joining host and sensor ends over the link
`timescale 1ns/10ps
module humidity_temp_i2c_readout_tb;
  import hti_pkg::*;
  logic        i_sys_clk = 0, i_rst_n = 0, i_fast = 0, i_meas_req = 0, i_fetch_req = 0;
  logic [2:0]  i_fetch_len = 3'h1;
  logic [1:0]  i_res_sel = 2'h3;
  logic [13:0] i_hum_value = 14'h2A5B, i_temp_value = 14'h1C3D;
  logic        o_core_on, o_meas_done, o_result_fresh, o_busy, o_done, o_addr_nack;
  logic [31:0] o_rx_word;
  int          n_mismatch = 0, checks = 0, cnt, on_cyc = 0, on_len = 0;
  hti_i2c_if bus ();
  // short conversion counts keep the run small
  hti_sensor_dev #(.WAKE_CYC(20), .CONV8_CYC(30), .CONV10_CYC(40), .CONV12_CYC(50),
    .CONV14_CYC(60)) hti_sensor_dev_inst (.i_sys_clk, .i_rst_n, .bus(bus), .i_res_sel,
    .i_hum_value, .i_temp_value, .o_core_on, .o_meas_done, .o_result_fresh);
  hti_i2c_host hti_i2c_host_inst (.i_sys_clk, .i_rst_n, .bus(bus), .i_fast, .i_meas_req,
    .i_fetch_req, .i_fetch_len, .o_busy, .o_done, .o_addr_nack, .o_rx_word);
  hti_link_sva hti_link_sva_inst (.i_sys_clk, .i_rst_n, .scl_m_oe(bus.scl_m_oe),
    .sda_m_oe(bus.sda_m_oe), .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe),
    .scl(bus.scl), .sda(bus.sda));
  initial
  begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // length of the powered-up phase, latched at completion
  always @(posedge i_sys_clk)
  begin
    on_cyc <= (o_core_on === 1'b1) ? on_cyc + 1 : 0;
    if (o_meas_done === 1'b1)
      on_len <= on_cyc;
  end
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait, a hang counts as a mismatch
  task automatic wait_for(ref logic s, input logic v, input int lim);
    cnt = 0;
    while (s !== v && cnt < lim)
    begin
      @(posedge i_sys_clk);
      #1;
      cnt++;
    end
    if (cnt >= lim)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  // one request through the host command port, judged at its done pulse
  task automatic xfer(input logic meas, input logic [2:0] len);
    @(posedge i_sys_clk);
    i_meas_req <= meas;
    i_fetch_req <= !meas;
    i_fetch_len <= len;
    @(posedge i_sys_clk);
    i_meas_req <= 1'b0;
    i_fetch_req <= 1'b0;
    wait_for(o_done, 1'b1, 60000);
    cmp(o_addr_nack, 1'b0);
    cmp(o_busy, 1'b0);
  endtask
  // measure at one resolution, wait for the cycle to end, then fetch all four bytes
  task automatic s_measure(input logic [1:0] res, input logic [13:0] mask, input int conv);
    @(posedge i_sys_clk);
    i_fast <= 1'b1;
    i_res_sel <= res;
    on_len = 0;
    xfer(1'b1, 3'h0);
    wait_for(o_core_on, 1'b0, 2000);
    cmp(on_len >= 19 + 2 * conv && on_len <= 22 + 2 * conv, 1'b1);
    cmp(o_result_fresh, 1'b1);
    xfer(1'b0, 3'h4);
    cmp(o_rx_word & 32'hFFFFFFFC, {HTI_STAT_VALID, i_hum_value & mask,
      i_temp_value & mask, 2'b00});
  endtask
  initial
  begin
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    cmp(o_core_on, 1'b0);
    // first fetch at the slow rate, before any measurement has finished
    xfer(1'b0, 3'h1);
    cmp(o_rx_word[7:6], HTI_STAT_STALE);
    s_measure(HTI_RES_8, HTI_MASK_8, 30);
    s_measure(HTI_RES_10, HTI_MASK_10, 40);
    s_measure(HTI_RES_12, HTI_MASK_12, 50);
    s_measure(HTI_RES_14, HTI_MASK_14, 60);
    // short fetch after a full read returns the stale code
    xfer(1'b0, 3'h2);
    cmp(o_rx_word[15:0], {HTI_STAT_STALE, i_hum_value});
    test_done();
  end
endmodule
